/* logic/sio_map.vh */
// Register map, field layout, reset values and timing constants of the switching IO block.
// Summary of operation
// - One shared level bit: 0 sinking, 1 sourcing.
// - First pin direction: 0 output, 1 input.
// - Polarity bit: 0 active high, 1 active low.
// - Input function: none, measurement trigger, teach request.
// - Output function: none, area, warning, trigger output.
// - Time module: off, start, off delay, stretch, suppress.
// - Sixteen-bit millisecond delay per pin, default zero.
// - Thirty-two bit area mask assigns areas to pin.
// - Second pin mirrors first, defaults to warning output.
// - Cascade function bit: 0 slave, 1 master.
// - Master triggers every cycle time, default 1 ms.
// - Trigger pulse width in microseconds, default 100.
// - Scan starts after trigger delay, default 500 us.
`ifndef SIO_MAP_VH
`define SIO_MAP_VH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define SIO_IDX_PA_FLAGS 8'h00
`define SIO_IDX_PA_MODE 8'h01
`define SIO_IDX_PA_DELAY 8'h02
`define SIO_IDX_PA_MASK 8'h04
`define SIO_IDX_PB_FLAGS 8'h08
`define SIO_IDX_PB_MODE 8'h09
`define SIO_IDX_PB_DELAY 8'h0a
`define SIO_IDX_PB_MASK 8'h0c
`define SIO_CASC_BASE 8'h10
`define SIO_IDX_CASC_FLAGS 8'h10
`define SIO_IDX_CASC_SCAN 8'h11
`define SIO_IDX_CASC_WIDTH 8'h13
`define SIO_IDX_CASC_PERIOD 8'h15
`define SIO_IDX_STATUS 8'h18

// ****************************************************************
// Flag fields.
// ****************************************************************
`define SIO_F_LEVEL 0
`define SIO_F_DIR 1
`define SIO_F_POL 2
`define SIO_F_IN_LO 3
`define SIO_F_IN_HI 4
`define SIO_F_OUT_LO 5
`define SIO_F_OUT_HI 6
`define SIO_C_EN 0
`define SIO_C_MASTER 1

`define SIO_IN_TRIG 2'h1
`define SIO_IN_TEACH 2'h2
`define SIO_OUT_AREA 2'h1
`define SIO_OUT_WARN 2'h2
`define SIO_OUT_TRIG 2'h3
`define SIO_TM_START 3'h1
`define SIO_TM_OFF 3'h2
`define SIO_TM_STRETCH 3'h3
`define SIO_TM_SUPPR 3'h4

// ****************************************************************
// Reset values.
// ****************************************************************
`define SIO_RST_PA_FLAGS 7'h0b
`define SIO_RST_PB_FLAGS 7'h40
`define SIO_RST_MODE 3'h0
`define SIO_RST_DELAY 16'h0000
`define SIO_RST_MASK 32'h00000000
`define SIO_RST_CASC 2'h0
`define SIO_RST_SCAN 16'h01f4
`define SIO_RST_WIDTH 16'h0064
`define SIO_RST_PERIOD 16'h0001

// ****************************************************************
// Timing.
// ****************************************************************
`define SIO_CLK_PERIOD_NS 100
`define SIO_US_NS 1000
`define SIO_CYC_PER_US (`SIO_US_NS / `SIO_CLK_PERIOD_NS)
`define SIO_US_PER_MS 1000

`endif

/* logic/sio_top.v */
// Switching IO pins, cascade trigger and their AHB-Lite register file.
`timescale 1ns/10ps
`include "sio_map.vh"

// ****************************************************************
// One configurable pin: synchroniser, time module, output stage.
// ****************************************************************
module sio_pin
(
	input wire hclk, // System clock
	input wire hresetn, // Asynchronous reset, active low
	input wire ms_tick, // One-cycle pulse each millisecond
	input wire src_drive, // 1 sourcing, 0 sinking
	input wire dir_in, // 1 pin is an input
	input wire pol, // 1 active low
	input wire [1:0] in_fn, // Input function
	input wire [1:0] out_fn, // Output function
	input wire [2:0] tm_mode, // Time module mode
	input wire [15:0] delay_ms, // Time module delay
	input wire [31:0] area_mask, // Assigned areas
	input wire [31:0] area_state, // Area results
	input wire warning, // Warning condition
	input wire trig_pulse, // Cascade trigger pulse
	input wire pin_in, // Pin level from outside
	output reg pin_out, // Pin level driven
	output reg pin_oe, // Pin driven
	output reg meas_trig, // Trigger request pulse
	output reg teach_req, // Teach request pulse
	output reg active // Filtered logical state
);
	reg in_s1_reg, in_s2_reg, tm_d_reg, raw_d_reg, tm_next, out_act;
	reg [15:0] cnt_reg, cnt_next;
	wire in_act, raw, lvl, done;

	always @*
	begin
		case (out_fn)
		`SIO_OUT_AREA: out_act = |(area_state & area_mask);
		`SIO_OUT_WARN: out_act = warning;
		`SIO_OUT_TRIG: out_act = trig_pulse;
		default: out_act = 1'b0;
		endcase
	end

	assign in_act = in_s2_reg ^ pol;
	assign raw = dir_in ? in_act : out_act;
	assign done = cnt_reg >= delay_ms;
	assign lvl = active ^ pol;

	// Time module: count whole milliseconds from the relevant edge.
	always @*
	begin
		cnt_next = cnt_reg;
		tm_next = active;
		case (tm_mode)
		`SIO_TM_START, `SIO_TM_SUPPR:
		begin
			if (!raw)
			begin
				cnt_next = 16'h0000;
				tm_next = 1'b0;
			end
			else if (done)
				tm_next = 1'b1;
			else if (ms_tick)
				cnt_next = cnt_reg + 16'h0001;
		end
		`SIO_TM_OFF:
		begin
			if (raw)
			begin
				cnt_next = 16'h0000;
				tm_next = 1'b1;
			end
			else if (done)
				tm_next = 1'b0;
			else if (ms_tick)
				cnt_next = cnt_reg + 16'h0001;
		end
		`SIO_TM_STRETCH:
		begin
			if (raw && !raw_d_reg)
			begin
				cnt_next = 16'h0000;
				tm_next = 1'b1;
			end
			else if (active)
			begin
				if (!done && ms_tick)
					cnt_next = cnt_reg + 16'h0001;
				if (!raw && done)
					tm_next = 1'b0;
			end
		end
		default:
		begin
			cnt_next = 16'h0000;
			tm_next = raw;
		end
		endcase
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			in_s1_reg <= 1'b0;
			in_s2_reg <= 1'b0;
			raw_d_reg <= 1'b0;
			tm_d_reg <= 1'b0;
			cnt_reg <= 16'h0000;
			active <= 1'b0;
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
			meas_trig <= 1'b0;
			teach_req <= 1'b0;
		end
		else
		begin
			in_s1_reg <= pin_in;
			in_s2_reg <= in_s1_reg;
			raw_d_reg <= raw;
			cnt_reg <= cnt_next;
			active <= tm_next;
			tm_d_reg <= active;
			pin_out <= lvl;
			pin_oe <= !dir_in && (lvl == src_drive);
			meas_trig <= dir_in && in_fn == `SIO_IN_TRIG && active && !tm_d_reg;
			teach_req <= dir_in && in_fn == `SIO_IN_TEACH && active && !tm_d_reg;
		end
	end
endmodule // sio_pin

// ****************************************************************
// Top: register file, timebase, cascade trigger, two pins.
// ****************************************************************
module sio_top
(
	input wire hclk, // System clock, 10 MHz
	input wire hresetn, // Asynchronous reset, active low
	input wire hsel, // Slave select
	input wire [31:0] haddr, // Byte address
	input wire [1:0] htrans, // Transfer type
	input wire hwrite, // Write access
	input wire [2:0] hsize, // Transfer size
	input wire [31:0] hwdata, // Write data
	input wire hready, // Bus ready
	output reg [31:0] hrdata, // Read data
	output reg hreadyout, // Slave ready
	output reg hresp, // Response, always OKAY
	input wire [31:0] area_state, // Evaluation area results
	input wire warning, // Warning condition
	input wire pin_a_in, // First pin, level in
	output wire pin_a_out, // First pin, level out
	output wire pin_a_oe, // First pin, driven
	input wire pin_b_in, // Second pin, level in
	output wire pin_b_out, // Second pin, level out
	output wire pin_b_oe, // Second pin, driven
	input wire casc_in, // Cascade trigger line in
	output reg casc_out, // Cascade trigger line out
	output reg casc_oe, // Cascade trigger line driven
	output reg scan_start, // Start of scan, pulse
	output reg teach_req // Teach request, pulse
);
	localparam integer US_DIV = `SIO_CYC_PER_US - 1;
	localparam integer MS_DIV = `SIO_US_PER_MS - 1;
	localparam [3:0] US_LAST = US_DIV[3:0];
	localparam [9:0] MS_LAST = MS_DIV[9:0];

	reg [6:0] pa_flags_reg, pb_flags_reg;
	reg [2:0] pa_mode_reg, pb_mode_reg;
	reg [15:0] pa_delay_reg, pb_delay_reg, scan_delay_reg, width_reg, period_reg;
	reg [31:0] pa_mask_reg, pb_mask_reg, rd_next;
	reg [1:0] casc_reg;
	reg [7:0] wr_idx_reg;
	reg [3:0] us_cnt_reg;
	reg [9:0] ms_cnt_reg;
	reg [15:0] per_cnt_reg, pw_cnt_reg, dly_cnt_reg;
	reg wr_pend_reg, us_tick_reg, ms_tick_reg, pulse_reg, dly_pend_reg;
	reg ci_s1_reg, ci_s2_reg, ci_d_reg;
	wire [7:0] idx;
	wire addr_ok, take, casc_en, master, fire, slave_edge, trig_any;
	wire pa_trig, pb_trig, pa_teach, pb_teach, pa_act, pb_act;

	assign idx = haddr[9:2];
	assign addr_ok = haddr[31:10] == 22'h000000;
	assign take = hsel && hready && htrans[1];
	assign casc_en = casc_reg[`SIO_C_EN];
	assign master = casc_reg[`SIO_C_MASTER];

	// ****************************************************************
	// Bus slave: zero wait states, read data registered at address phase.
	// ****************************************************************
	always @*
	begin
		rd_next = 32'h00000000;
		if (addr_ok)
		begin
			case (idx)
			`SIO_IDX_PA_FLAGS: rd_next = {25'h0000000, pa_flags_reg};
			`SIO_IDX_PA_MODE: rd_next = {29'h00000000, pa_mode_reg};
			`SIO_IDX_PA_DELAY: rd_next = {16'h0000, pa_delay_reg};
			`SIO_IDX_PA_MASK: rd_next = pa_mask_reg;
			`SIO_IDX_PB_FLAGS: rd_next = {25'h0000000, pb_flags_reg};
			`SIO_IDX_PB_MODE: rd_next = {29'h00000000, pb_mode_reg};
			`SIO_IDX_PB_DELAY: rd_next = {16'h0000, pb_delay_reg};
			`SIO_IDX_PB_MASK: rd_next = pb_mask_reg;
			`SIO_IDX_CASC_FLAGS: rd_next = {30'h00000000, casc_reg};
			`SIO_IDX_CASC_SCAN: rd_next = {16'h0000, scan_delay_reg};
			`SIO_IDX_CASC_WIDTH: rd_next = {16'h0000, width_reg};
			`SIO_IDX_CASC_PERIOD: rd_next = {16'h0000, period_reg};
			`SIO_IDX_STATUS: rd_next = {26'h0000000, dly_pend_reg, pulse_reg,
				pb_act, pa_act, pin_b_out, pin_a_out};
			default: rd_next = 32'h00000000;
			endcase
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 8'h00;
			pa_flags_reg <= `SIO_RST_PA_FLAGS;
			pa_mode_reg <= `SIO_RST_MODE;
			pa_delay_reg <= `SIO_RST_DELAY;
			pa_mask_reg <= `SIO_RST_MASK;
			pb_flags_reg <= `SIO_RST_PB_FLAGS;
			pb_mode_reg <= `SIO_RST_MODE;
			pb_delay_reg <= `SIO_RST_DELAY;
			pb_mask_reg <= `SIO_RST_MASK;
			casc_reg <= `SIO_RST_CASC;
			scan_delay_reg <= `SIO_RST_SCAN;
			width_reg <= `SIO_RST_WIDTH;
			period_reg <= `SIO_RST_PERIOD;
		end
		else
		begin
			if (hready)
			begin
				wr_pend_reg <= take && hwrite && addr_ok;
				wr_idx_reg <= idx;
				if (take && !hwrite)
					hrdata <= rd_next;
			end
			if (wr_pend_reg)
			begin
				case (wr_idx_reg)
				`SIO_IDX_PA_FLAGS: pa_flags_reg <= hwdata[6:0];
				`SIO_IDX_PA_MODE: pa_mode_reg <= hwdata[2:0];
				`SIO_IDX_PA_DELAY: pa_delay_reg <= hwdata[15:0];
				`SIO_IDX_PA_MASK: pa_mask_reg <= hwdata;
				`SIO_IDX_PB_FLAGS: pb_flags_reg <= {hwdata[6:1], 1'b0};
				`SIO_IDX_PB_MODE: pb_mode_reg <= hwdata[2:0];
				`SIO_IDX_PB_DELAY: pb_delay_reg <= hwdata[15:0];
				`SIO_IDX_PB_MASK: pb_mask_reg <= hwdata;
				`SIO_IDX_CASC_FLAGS: casc_reg <= hwdata[1:0];
				`SIO_IDX_CASC_SCAN: scan_delay_reg <= hwdata[15:0];
				`SIO_IDX_CASC_WIDTH: width_reg <= hwdata[15:0];
				`SIO_IDX_CASC_PERIOD: period_reg <= hwdata[15:0];
				default: casc_reg <= casc_reg;
				endcase
			end
		end
	end

	// ****************************************************************
	// Timebase: microsecond and millisecond enable pulses.
	// ****************************************************************
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			us_cnt_reg <= 4'h0;
			ms_cnt_reg <= 10'h000;
			us_tick_reg <= 1'b0;
			ms_tick_reg <= 1'b0;
		end
		else
		begin
			us_tick_reg <= us_cnt_reg == US_LAST;
			ms_tick_reg <= us_cnt_reg == US_LAST && ms_cnt_reg == MS_LAST;
			if (us_cnt_reg == US_LAST)
			begin
				us_cnt_reg <= 4'h0;
				ms_cnt_reg <= (ms_cnt_reg == MS_LAST) ? 10'h000 : ms_cnt_reg + 10'h001;
			end
			else
				us_cnt_reg <= us_cnt_reg + 4'h1;
		end
	end

	// ****************************************************************
	// Cascade: master period, trigger pulse, delay until scan.
	// ****************************************************************
	assign fire = casc_en && master && ms_tick_reg && per_cnt_reg + 16'h0001 >= period_reg;
	assign slave_edge = casc_en && !master && ci_s2_reg && !ci_d_reg;
	assign trig_any = fire || slave_edge || pa_trig || pb_trig;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ci_s1_reg <= 1'b0;
			ci_s2_reg <= 1'b0;
			ci_d_reg <= 1'b0;
			per_cnt_reg <= 16'h0000;
			pw_cnt_reg <= 16'h0000;
			pulse_reg <= 1'b0;
			dly_cnt_reg <= 16'h0000;
			dly_pend_reg <= 1'b0;
			scan_start <= 1'b0;
			casc_out <= 1'b0;
			casc_oe <= 1'b0;
			teach_req <= 1'b0;
		end
		else
		begin
			ci_s1_reg <= casc_in;
			ci_s2_reg <= ci_s1_reg;
			ci_d_reg <= ci_s2_reg;
			if (!(casc_en && master) || fire)
				per_cnt_reg <= 16'h0000;
			else if (ms_tick_reg)
				per_cnt_reg <= per_cnt_reg + 16'h0001;
			if (fire)
			begin
				pulse_reg <= 1'b1;
				pw_cnt_reg <= 16'h0000;
			end
			else if (pulse_reg)
			begin
				if (pw_cnt_reg >= width_reg)
					pulse_reg <= 1'b0;
				else if (us_tick_reg)
					pw_cnt_reg <= pw_cnt_reg + 16'h0001;
			end
			// A new trigger while waiting restarts the wait.
			scan_start <= 1'b0;
			if (trig_any)
			begin
				dly_pend_reg <= 1'b1;
				dly_cnt_reg <= 16'h0000;
			end
			else if (dly_pend_reg)
			begin
				if (dly_cnt_reg >= scan_delay_reg)
				begin
					dly_pend_reg <= 1'b0;
					scan_start <= 1'b1;
				end
				else if (us_tick_reg)
					dly_cnt_reg <= dly_cnt_reg + 16'h0001;
			end
			casc_out <= pulse_reg;
			casc_oe <= casc_en && master;
			teach_req <= pa_teach || pb_teach;
		end
	end

	// ****************************************************************
	// The two pins.
	// ****************************************************************
	sio_pin u_pin_a
	(
		.hclk(hclk), .hresetn(hresetn), .ms_tick(ms_tick_reg),
		.src_drive(pa_flags_reg[`SIO_F_LEVEL]),
		.dir_in(pa_flags_reg[`SIO_F_DIR]), .pol(pa_flags_reg[`SIO_F_POL]),
		.in_fn(pa_flags_reg[`SIO_F_IN_HI:`SIO_F_IN_LO]), .tm_mode(pa_mode_reg),
		.out_fn(pa_flags_reg[`SIO_F_OUT_HI:`SIO_F_OUT_LO]), .delay_ms(pa_delay_reg),
		.area_mask(pa_mask_reg), .area_state(area_state), .warning(warning),
		.trig_pulse(pulse_reg), .pin_in(pin_a_in), .pin_out(pin_a_out),
		.pin_oe(pin_a_oe), .meas_trig(pa_trig), .teach_req(pa_teach), .active(pa_act)
	);

	sio_pin u_pin_b
	(
		.hclk(hclk), .hresetn(hresetn), .ms_tick(ms_tick_reg),
		.src_drive(pa_flags_reg[`SIO_F_LEVEL]),
		.dir_in(pb_flags_reg[`SIO_F_DIR]), .pol(pb_flags_reg[`SIO_F_POL]),
		.in_fn(pb_flags_reg[`SIO_F_IN_HI:`SIO_F_IN_LO]), .tm_mode(pb_mode_reg),
		.out_fn(pb_flags_reg[`SIO_F_OUT_HI:`SIO_F_OUT_LO]), .delay_ms(pb_delay_reg),
		.area_mask(pb_mask_reg), .area_state(area_state), .warning(warning),
		.trig_pulse(pulse_reg), .pin_in(pin_b_in), .pin_out(pin_b_out),
		.pin_oe(pin_b_oe), .meas_trig(pb_trig), .teach_req(pb_teach), .active(pb_act)
	);
endmodule // sio_top

/* test/sio_peer_model.sv */
// Far side: a cascade master peer and the outside switching input.
`timescale 1ns/10ps
module sio_peer_model
#(
	parameter int WIDTH_CYC = 1000
)
(
	input logic hclk, // Clock
	input logic fire, // Send one trigger pulse
	input logic ext_a, // Outside level on the first pin
	input logic pin_a_out, // First pin out
	input logic pin_a_oe, // First pin driven
	input logic casc_out, // Block trigger out
	input logic casc_oe, // Block trigger driven
	output logic pin_a_in, // First pin wire
	output logic casc_in // Cascade wire
);
// ****************************************************************
// Wire levels and the peer's trigger pulse.
// ****************************************************************
int cnt = 0;
assign pin_a_in = pin_a_oe ? pin_a_out : ext_a;
assign casc_in = casc_oe ? casc_out : (cnt != 0);
always @(posedge hclk)
	if (fire)
		cnt <= WIDTH_CYC;
	else if (cnt != 0)
		cnt <= cnt - 1;
endmodule // sio_peer_model

/* test/sio_top_asserts.sv */
// Concurrent checks on the ports of the switching IO block.
`timescale 1ns/10ps
module sio_top_asserts
(
	input logic hclk, // Clock
	input logic hresetn, // Reset, active low
	input logic hsel, // Slave select
	input logic [1:0] htrans, // Transfer type
	input logic hwrite, // Write access
	input logic hready, // Bus ready
	input logic [31:0] hrdata, // Read data
	input logic hreadyout, // Slave ready
	input logic hresp, // Response
	input logic pin_a_in, // First pin in
	input logic pin_a_out, // First pin out
	input logic pin_a_oe, // First pin driven
	input logic pin_b_out, // Second pin out
	input logic pin_b_oe, // Second pin driven
	input logic casc_in, // Cascade line in
	input logic casc_out, // Cascade line out
	input logic casc_oe, // Cascade line driven
	input logic scan_start, // Scan start pulse
	input logic teach_req // Teach pulse
);
// ****************************************************************
// Cycle counters since trigger events.
// ****************************************************************
logic co_reg, ci_reg, pa_reg, seen_reg;
logic [15:0] hi_reg, gap_reg, tc_reg;
always_ff @(posedge hclk or negedge hresetn)
	if (!hresetn)
	begin
		co_reg <= 1'b0;
		ci_reg <= 1'b0;
		pa_reg <= 1'b0;
		seen_reg <= 1'b0;
		hi_reg <= 16'h0000;
		gap_reg <= 16'h0000;
		tc_reg <= 16'hffff;
	end
	else
	begin
		co_reg <= casc_out;
		ci_reg <= casc_in;
		pa_reg <= pin_a_in;
		hi_reg <= casc_out ? hi_reg + 16'h0001 : 16'h0000;
		if (casc_out && !co_reg)
			seen_reg <= 1'b1;
		if (casc_out && !co_reg)
			gap_reg <= 16'h0001;
		else if (gap_reg != 16'hffff)
			gap_reg <= gap_reg + 16'h0001;
		if ((casc_out && !co_reg) || (casc_in && !ci_reg) || (pin_a_in && !pa_reg))
			tc_reg <= 16'h0000;
		else if (tc_reg != 16'hffff)
			tc_reg <= tc_reg + 16'h0001;
	end
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
property p_okay; hreadyout && !hresp; endproperty
property p_hold; !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
property p_level; pin_a_oe && pin_b_oe |-> pin_a_out == pin_b_out; endproperty
property p_master; casc_out |-> casc_oe; endproperty
property p_period; casc_out && !co_reg && seen_reg |-> gap_reg >= 16'h2706; endproperty
property p_width; $fell(casc_out) |-> hi_reg >= 16'h03de; endproperty
property p_scan; scan_start |-> tc_reg >= 16'h1374 ##1 !scan_start; endproperty
property p_teach; teach_req |=> !teach_req; endproperty
a_okay: assert property (p_okay) else $error("bus response not OKAY");
a_hold: assert property (p_hold) else $error("read data moved without read");
a_level: assert property (p_level) else $error("pins drive different levels");
a_master: assert property (p_master) else $error("trigger out while not driven");
a_period: assert property (p_period) else $error("trigger period too short");
a_width: assert property (p_width) else $error("trigger pulse too short");
a_scan: assert property (p_scan) else $error("scan started too early");
a_teach: assert property (p_teach) else $error("teach pulse too long");
c_trig: cover property (casc_out && !co_reg);
c_scan: cover property (scan_start);
c_teach: cover property (teach_req);
endmodule // sio_top_asserts

bind sio_top sio_top_asserts chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .pin_a_in(pin_a_in), .pin_a_out(pin_a_out),
	.pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .casc_in(casc_in),
	.casc_out(casc_out), .casc_oe(casc_oe), .scan_start(scan_start), .teach_req(teach_req));

/* test/sio_top_tb_top.sv */
// Self-checking testbench of the switching IO block.
`timescale 1ns/10ps
`include "sio_map.vh"
module sio_top_tb_top;
// ****************************************************************
// Signals, design and far side.
// ****************************************************************
logic hclk, hresetn, hsel, hwrite, warning, ext_a, fire;
logic [1:0] htrans;
logic [2:0] hsize;
logic [31:0] haddr, hwdata, area_state, d;
wire [31:0] hrdata;
wire hreadyout, hresp, pin_a_in, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
wire casc_in, casc_out, casc_oe, scan_start, teach_req;
int mismatches, checked, cyc, i, n, w, s, p;
logic [7:0] ri [13];
logic [31:0] rv [13];
sio_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .area_state(area_state),
	.warning(warning), .pin_a_in(pin_a_in), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
	.pin_b_in(pin_b_out), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .casc_in(casc_in),
	.casc_out(casc_out), .casc_oe(casc_oe), .scan_start(scan_start), .teach_req(teach_req));
sio_peer_model peer_u (.hclk(hclk), .fire(fire), .ext_a(ext_a), .pin_a_out(pin_a_out),
	.pin_a_oe(pin_a_oe), .casc_out(casc_out), .casc_oe(casc_oe), .pin_a_in(pin_a_in),
	.casc_in(casc_in));
// ****************************************************************
// Bus cycles, comparison and closing.
// ****************************************************************
task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
	output logic [31:0] rdv);
	@(posedge hclk);
	hsel <= 1'b1;
	htrans <= 2'h2;
	hwrite <= wr;
	haddr <= {22'h000000, idx, 2'h0};
	@(posedge hclk);
	while (hreadyout !== 1'b1) @(posedge hclk);
	hsel <= 1'b0;
	htrans <= 2'h0;
	hwdata <= wd;
	@(posedge hclk);
	while (hreadyout !== 1'b1) @(posedge hclk);
	rdv = hrdata;
endtask
task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
	logic [31:0] x;
	bus(1'b1, idx, wd, x);
endtask
task automatic rd(input logic [7:0] idx, output logic [31:0] rdv);
	bus(1'b0, idx, 32'h00000000, rdv);
endtask
task automatic cmp(input logic [31:0] g, input logic [31:0] e);
	checked++;
	if (g !== e)
	begin
		mismatches++;
		$display("Error at %0t: got %h, expected %h", $time, g, e);
	end
endtask
task automatic close_out;
	$display("Comparisons %0d, mismatches %0d", checked, mismatches);
	if (mismatches == 0 && checked > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
endtask
initial
begin
	hclk = 1'b0;
	forever #50 hclk = ~hclk;
end
always @(posedge hclk)
begin
	cyc++;
	if (cyc == 100000)
	begin
		mismatches++;
		close_out;
	end
end
// ****************************************************************
// Main sequence.
// ****************************************************************
initial
begin
	{hresetn, hsel, hwrite, warning, ext_a, fire, htrans} = 8'h00;
	hsize = 3'h2;
	{haddr, hwdata, area_state} = 96'h0;
	ri = '{`SIO_IDX_PA_FLAGS, `SIO_IDX_PA_MODE, `SIO_IDX_PA_DELAY, `SIO_IDX_PA_MASK,
		`SIO_IDX_PB_FLAGS, `SIO_IDX_PB_MODE, `SIO_IDX_PB_DELAY, `SIO_IDX_PB_MASK,
		`SIO_IDX_CASC_FLAGS, `SIO_IDX_CASC_SCAN, `SIO_IDX_CASC_WIDTH,
		`SIO_IDX_CASC_PERIOD, 8'h3f};
	rv = '{32'h0b, 32'h0, 32'h0, 32'h0, 32'h40, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1f4,
		32'h64, 32'h1, 32'h0};
	repeat (2) @(posedge hclk);
	hresetn <= 1'b1;
	for (i = 0; i < 13; i++)
	begin
		rd(ri[i], d);
		cmp(d, rv[i]);
	end
	wr(`SIO_IDX_PA_DELAY, 32'hffff);
	rd(`SIO_IDX_PA_DELAY, d);
	cmp(d, 32'hffff);
	wr(`SIO_IDX_PA_MASK, 32'hffffffff);
	rd(`SIO_IDX_PA_MASK, d);
	cmp(d, 32'hffffffff);
	warning <= 1'b1;
	repeat (6) @(posedge hclk);
	cmp({pin_b_out, pin_b_oe}, 2'b11);
	wr(`SIO_IDX_PB_FLAGS, 32'h44);
	repeat (6) @(posedge hclk);
	cmp({pin_b_out, pin_b_oe}, 2'b00);
	wr(`SIO_IDX_PA_FLAGS, 32'h0a);
	repeat (6) @(posedge hclk);
	cmp({pin_b_out, pin_b_oe}, 2'b01);
	wr(`SIO_IDX_PB_FLAGS, 32'h20);
	wr(`SIO_IDX_PB_MASK, 32'h8);
	area_state <= 32'h8;
	repeat (6) @(posedge hclk);
	cmp(pin_b_out, 1'b1);
	area_state <= 32'hfffffff7;
	repeat (6) @(posedge hclk);
	cmp(pin_b_out, 1'b0);
	warning <= 1'b0;
	wr(`SIO_IDX_PB_FLAGS, 32'h40);
	wr(`SIO_IDX_PB_MODE, `SIO_TM_START);
	wr(`SIO_IDX_PB_DELAY, 32'h1);
	repeat (6) @(posedge hclk);
	warning <= 1'b1;
	repeat (9000) @(posedge hclk);
	cmp(pin_b_out, 1'b0);
	repeat (12000) @(posedge hclk);
	cmp(pin_b_out, 1'b1);
	wr(`SIO_IDX_PA_FLAGS, 32'h13);
	ext_a <= 1'b1;
	for (n = 0; n < 20 && teach_req !== 1'b1; n++) @(posedge hclk);
	cmp(n < 20, 1'b1);
	ext_a <= 1'b0;
	wr(`SIO_IDX_CASC_FLAGS, 32'h1);
	wr(`SIO_IDX_CASC_SCAN, 32'h258);
	fire <= 1'b1;
	@(posedge hclk);
	fire <= 1'b0;
	for (n = 0; n < 8000 && scan_start !== 1'b1; n++) @(posedge hclk);
	cmp(n >= 5990 && n <= 6030, 1'b1);
	cmp(casc_oe, 1'b0);
	wr(`SIO_IDX_CASC_SCAN, 32'h1f4);
	wr(`SIO_IDX_CASC_FLAGS, 32'h3);
	for (n = 0; n < 20000 && casc_out !== 1'b1; n++) @(posedge hclk);
	cmp(casc_oe, 1'b1);
	{w, s, p} = 0;
	for (n = 1; n < 12000 && p == 0; n++)
	begin
		@(posedge hclk);
		if (scan_start === 1'b1)
			s = n;
		if (casc_out === 1'b1 && w == n - 1)
			w = n;
		else if (casc_out === 1'b1)
			p = n;
	end
	cmp(w >= 989 && w <= 1019, 1'b1);
	cmp(p >= 9990 && p <= 10010, 1'b1);
	cmp(s >= 4985 && s <= 5015, 1'b1);
	repeat (1200) @(posedge hclk);
	wr(`SIO_IDX_CASC_FLAGS, 32'h0);
	wr(`SIO_IDX_PA_FLAGS, 32'h0b);
	ext_a <= 1'b1;
	for (n = 0; n < 8000 && scan_start !== 1'b1; n++) @(posedge hclk);
	cmp(n >= 4990 && n <= 5030, 1'b1);
	rd(`SIO_IDX_STATUS, d);
	cmp(d, 32'h0f);
	wr(`SIO_IDX_PB_MODE, `SIO_TM_OFF);
	wr(`SIO_IDX_PB_DELAY, 32'h2);
	warning <= 1'b0;
	repeat (100) @(posedge hclk);
	cmp(pin_b_out, 1'b1);
	repeat (21000) @(posedge hclk);
	cmp(pin_b_out, 1'b0);
	close_out;
end
endmodule // sio_top_tb_top
